//--- dv/smcc_chk.sv
`timescale 1ns/1ps
module smcc_chk (
	// clock and reset
	input wire logic                 clk,
	input wire logic                 resetn,
	// watched ports
	input wire smcc_pkg::smcc_mode_e mode,
	input wire logic                 disc_req,
	input wire logic                 disc_done,
	input wire logic                 disc_found,
	input wire logic                 addr_ok,
	input wire logic                 route_ok,
	input wire logic                 tx_ack,
	input wire smcc_pkg::smcc_byte_s rf_tx,
	input wire logic                 rf_tx_ready,
	input wire smcc_pkg::smcc_byte_s rf_rx,
	input wire logic                 rf_rx_ready,
	input wire logic                 nv_wr,
	input wire logic                 asleep
);
	import smcc_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_disc_pulse: assert property (disc_req |=> !disc_req)
		else $error("discovery request too long");
	chk_send_known: assert property ((mode == M_SEND && $past(mode) == M_DISC)
		|-> $past(addr_ok && route_ok)) else $error("send without address or route");
	chk_drop_nofind: assert property ((mode == M_DISC && disc_done && !disc_found)
		|=> mode == M_IDLE) else $error("failed discovery kept packet");
	chk_ack_idle: assert property ((mode == M_ACKW && tx_ack) |=> mode == M_IDLE)
		else $error("ack did not end transfer");
	chk_tx_hold: assert property ((rf_tx.valid && !rf_tx_ready)
		|=> rf_tx.valid && $stable(rf_tx.data)) else $error("radio byte dropped");
	chk_rx_last: assert property ((rf_rx.valid && rf_rx_ready && rf_rx.last)
		|=> mode == M_IDLE) else $error("receive did not end");
	chk_nv_pulse: assert property (nv_wr |=> !nv_wr)
		else $error("store pulse too long");
	chk_sleep_flag: assert property (asleep == (mode == M_SLEEP))
		else $error("sleep flag wrong");

	cover property (mode == M_CMD);
	cover property (rf_tx.valid && rf_tx_ready);
	cover property (rf_rx.valid && rf_rx_ready);
	cover property (mode == M_SLEEP);
endmodule : smcc_chk

//--- dv/smcc_host.sv
`timescale 1ns/1ps
module smcc_host #(
	parameter int DIV = 20
) (
	// clock
	input  wire logic clk,
	// serial lines
	input  wire logic rxd,
	output logic      txd
);
	logic [7:0] rxq[$];
	logic [7:0] b;

	initial txd = 1'b1;

	// one 8N1 frame, lsb first; line idles high
	task automatic send(input logic [7:0] d);
		logic [9:0] fr;
		fr = {1'b1, d, 1'b0};
		@(posedge clk);
		for (int i = 0; i < 10; i++) begin
			txd <= fr[i];
			repeat (DIV) @(posedge clk);
		end
	endtask : send

	// sample mid-bit; a frame with a low stop bit is thrown away
	always begin
		@(negedge rxd);
		repeat (DIV / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (DIV) @(posedge clk);
			b[i] = rxd;
		end
		repeat (DIV) @(posedge clk);
		if (rxd) rxq.push_back(b);
	end
endmodule : smcc_host

//--- dv/smcc_tb_top.sv
`timescale 1ns/1ps
module smcc_tb_top;
	import smcc_pkg::*;
	logic                clk, resetn, wr, rd, uart_rxd, uart_txd, cts_n, sleep_rq, asleep;
	logic [7:0]          addr;
	logic [31:0]         wdata, rdata;
	logic                rf_tx_ready, addr_ok, route_ok, disc_req, disc_route;
	logic                disc_done, disc_found, tx_ack, rf_rx_ready, nv_valid, nv_wr;
	smcc_byte_s          rf_tx, rf_rx;
	smcc_cfg_s           nv_rdata, nv_wdata;
	smcc_mode_e          mode;
	int                  n_mismatch, cmp_count;
	logic [7:0]          ta[5] = '{A_SW, A_ESC, A_CMDTO, A_BAUD, 8'h20};
	logic [31:0]         tv[5] = '{32'(SW_RST), 32'(ESC_RST), 32'(CMDTO_RST), 32'(BAUD_RST), 0};

	smcc_top #(.CLK_HZ(192000), .MS_CYC(20)) smcc_top_i (.clk(clk), .resetn(resetn),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .uart_rxd(uart_rxd),
		.uart_txd(uart_txd), .cts_n(cts_n), .sleep_rq(sleep_rq), .asleep(asleep),
		.rf_tx(rf_tx), .rf_tx_ready(rf_tx_ready), .addr_ok(addr_ok), .route_ok(route_ok),
		.disc_req(disc_req), .disc_route(disc_route), .disc_done(disc_done),
		.disc_found(disc_found), .tx_ack(tx_ack), .rf_rx(rf_rx), .rf_rx_ready(rf_rx_ready),
		.nv_rdata(nv_rdata), .nv_valid(nv_valid), .nv_wdata(nv_wdata), .nv_wr(nv_wr),
		.mode(mode));
	smcc_host #(.DIV(20)) smcc_host_i (.clk(clk), .rxd(uart_txd), .txd(uart_rxd));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 check(rdata, e);
	endtask : rd_reg

	task automatic send_str(input string s);
		foreach (s[i]) smcc_host_i.send(s[i]);
	endtask : send_str

	// bounded wait for the whole reply, then byte by byte
	task automatic expect_str(input string s);
		for (int k = 0; k < 20000 && smcc_host_i.rxq.size() < s.len(); k++) @(posedge clk);
		foreach (s[i]) check(32'(smcc_host_i.rxq.pop_front()), 32'(s[i]));
	endtask : expect_str

	task automatic wait_mode(input smcc_mode_e m);
		for (int k = 0; k < 3000 && mode !== m; k++) @(posedge clk);
		check(32'(mode), 32'(m));
	endtask : wait_mode

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test

	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		finish_test();
	end

	initial begin
		{resetn, wr, rd, addr, wdata, sleep_rq, nv_valid} = '0;
		// saved image differs from the defaults only in sw
		nv_rdata = smcc_cfg_s'({CFG_RST[$bits(smcc_cfg_s)-1:16], 16'h0123});
		{rf_tx_ready, addr_ok, route_ok, disc_done, disc_found, tx_ack, rf_rx} = '0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 5; i++) rd_reg(ta[i], tv[i]);
		$display("reset values done");
		// a shorter window keeps the run short and shows it is configurable
		wr_reg(A_SW, 32'h28);
		repeat (900) @(posedge clk);
		send_str("+++");
		expect_str("OK\015");
		wait_mode(M_CMD);
		send_str("ATBD\015");
		expect_str("0003\015");
		send_str("ATZZ\015");
		expect_str("ERROR\015");
		send_str("ATWR\015");
		expect_str("OK\015");
		send_str("AT\103\116\015");
		expect_str("OK\015");
		wait_mode(M_IDLE);
		$display("command state done");
		smcc_host_i.send(8'h55);
		for (int k = 0; k < 3000 && !disc_req; k++) @(posedge clk);
		check(32'(disc_route), 0);
		disc_done <= 1'b1;
		@(posedge clk);
		disc_done <= 1'b0;
		wait_mode(M_IDLE);
		addr_ok  <= 1'b1;
		route_ok <= 1'b1;
		smcc_host_i.send(8'hA7);
		for (int k = 0; k < 3000 && !rf_tx.valid; k++) @(posedge clk);
		check(32'({rf_tx.data, rf_tx.last}), 32'h14F);
		rf_tx_ready <= 1'b1;
		@(posedge clk);
		rf_tx_ready <= 1'b0;
		wait_mode(M_ACKW);
		tx_ack <= 1'b1;
		@(posedge clk);
		tx_ack <= 1'b0;
		wait_mode(M_IDLE);
		$display("transmit done");
		// the same packet twice: the host must see both copies
		rf_rx <= '{valid: 1'b1, data: 8'hC3, last: 1'b1};
		repeat (2) @(posedge clk);
		rf_rx <= '0;
		expect_str("\303\303");
		$display("receive done");
		wr_reg(A_CTRL, 32'h3);
		sleep_rq <= 1'b1;
		wait_mode(M_SLEEP);
		check(32'(asleep), 1);
		sleep_rq <= 1'b0;
		wait_mode(M_IDLE);
		$display("sleep done");
		// unsaved ctrl bits must be gone after a reset with a saved image
		nv_valid <= 1'b1;
		resetn   <= 1'b0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		rd_reg(A_SW, 32'h123);
		rd_reg(A_CTRL, 0);
		$display("restore done");
		finish_test();
	end
endmodule : smcc_tb_top

bind smcc_top smcc_chk smcc_chk_i (.*);

//--- logic/smcc_pkg.sv
package smcc_pkg;
	// timebase
	localparam int          CLK_NS     = 10;
	localparam int          MS_NS      = 1000000;
	// buffers
	localparam int          IBUF_LEN   = 72;
	localparam int          OBUF_LEN   = 16;
	localparam int          CTS_MARGIN = 17;
	// setting reset values
	localparam logic [15:0] SW_RST     = 16'h03E8;
	localparam logic [7:0]  ESC_RST    = 8'h2B;
	localparam logic [15:0] CMDTO_RST  = 16'h2710;
	localparam logic [2:0]  BAUD_RST   = 3'h3;
	localparam logic [15:0] GAP_RST    = 16'h0003;
	localparam logic [15:0] SLPER_RST  = 16'h03E8;
	localparam logic [15:0] ACK_MS     = 16'h0032;
	localparam int          BAUD_BPS [8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
	// register offsets
	localparam logic [7:0]  A_CTRL     = 8'h00;
	localparam logic [7:0]  A_SW       = 8'h04;
	localparam logic [7:0]  A_ESC      = 8'h08;
	localparam logic [7:0]  A_CMDTO    = 8'h0C;
	localparam logic [7:0]  A_BAUD     = 8'h10;
	localparam logic [7:0]  A_GAP      = 8'h14;
	localparam logic [7:0]  A_SLPER    = 8'h18;
	localparam logic [7:0]  A_STAT     = 8'h1C;
	// text codes
	localparam logic [7:0]  CH_A       = 8'h41;
	localparam logic [7:0]  CH_T       = 8'h54;
	localparam logic [7:0]  CH_CR      = 8'h0D;
	localparam logic [7:0]  CH_SP      = 8'h20;
	localparam logic [23:0] OK_STR     = 24'h4F4B0D;
	localparam logic [47:0] ERR_STR    = 48'h4552524F520D;
	localparam logic [15:0] CMD_SW     = 16'h4754;
	localparam logic [15:0] CMD_ESC    = 16'h4343;
	localparam logic [15:0] CMD_CMDTO  = 16'h4354;
	localparam logic [15:0] CMD_BAUD   = 16'h4244;
	localparam logic [15:0] CMD_GAP    = 16'h524F;
	localparam logic [15:0] CMD_APPLY  = 16'h4143;
	localparam logic [15:0] CMD_EXIT   = 16'h434E;
	localparam logic [15:0] CMD_SAVE   = 16'h5752;

	typedef struct packed {
		logic        cyc_en;
		logic        pin_en;
		logic        end_dev;
		logic [15:0] slper;
		logic [15:0] gap;
		logic [2:0]  baud;
		logic [15:0] cmd_to;
		logic [7:0]  esc;
		logic [15:0] sw;
	} smcc_cfg_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       last;
	} smcc_byte_s;

	typedef enum logic [2:0] {
		M_IDLE  = 3'b000,
		M_DISC  = 3'b001,
		M_SEND  = 3'b010,
		M_ACKW  = 3'b011,
		M_RX    = 3'b100,
		M_CMD   = 3'b101,
		M_SLEEP = 3'b110
	} smcc_mode_e;

	typedef enum logic [1:0] {
		R_NONE = 2'b00,
		R_OK   = 2'b01,
		R_ERR  = 2'b10,
		R_VAL  = 2'b11
	} smcc_rep_e;

	localparam smcc_cfg_s CFG_RST = '{cyc_en: 1'b0, pin_en: 1'b0, end_dev: 1'b0,
		slper: SLPER_RST, gap: GAP_RST, baud: BAUD_RST, cmd_to: CMDTO_RST,
		esc: ESC_RST, sw: SW_RST};
endpackage : smcc_pkg

//--- logic/smcc_top.sv
// Contract
// - idle goes to transmit, receive, command, sleep
// - send only with address and route known
// - address not found drops the packet
// - send once routed; failed route drops packet
// - retransmit when network acknowledgement missing
// - radio payload goes to serial output buffer
// - silence, three escapes, silence enters command
// - reply OK and CR after escape
// - command entry starts timeout, accepts commands
// - silence window and escape char configurable
// - baud setting defaults to code 3
// - command without parameter reads the setting
// - save command stores; reset restores saved
// - reply OK on success, ERROR on failure
// - settings staged until apply or exit
// - exit command applies and returns idle
// - command timeout returns to idle
// - pin sleep and cyclic sleep supported
// - start, eight data lsb first, stop
// - full 72 byte buffer triggers packetizing
// - data before escape still gets sent
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module smcc_top #(
	parameter int CLK_HZ    = 1000000000 / smcc_pkg::CLK_NS,
	parameter int MS_CYC    = smcc_pkg::MS_NS / smcc_pkg::CLK_NS,
	parameter int MAX_RETRY = 3
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 resetn,
	// register port
	input  wire logic [7:0]           addr,
	input  wire logic [31:0]          wdata,
	input  wire logic                 wr,
	input  wire logic                 rd,
	output logic [31:0]               rdata,
	// host serial pins
	input  wire logic                 uart_rxd,
	output logic                      uart_txd,
	output logic                      cts_n,
	// sleep
	input  wire logic                 sleep_rq,
	output logic                      asleep,
	// radio transmit side
	output smcc_pkg::smcc_byte_s      rf_tx,
	input  wire logic                 rf_tx_ready,
	input  wire logic                 addr_ok,
	input  wire logic                 route_ok,
	output logic                      disc_req,
	output logic                      disc_route,
	input  wire logic                 disc_done,
	input  wire logic                 disc_found,
	input  wire logic                 tx_ack,
	// radio receive side
	input  wire smcc_pkg::smcc_byte_s rf_rx,
	output logic                      rf_rx_ready,
	// nonvolatile store
	input  wire smcc_pkg::smcc_cfg_s  nv_rdata,
	input  wire logic                 nv_valid,
	output smcc_pkg::smcc_cfg_s       nv_wdata,
	output logic                      nv_wr,
	// status
	output smcc_pkg::smcc_mode_e      mode
);
	import smcc_pkg::*;

	localparam logic [19:0] MS_LAST = 20'(MS_CYC - 1);
	localparam logic [19:0] BDIV [8] = '{
		20'(CLK_HZ / BAUD_BPS[0]), 20'(CLK_HZ / BAUD_BPS[1]), 20'(CLK_HZ / BAUD_BPS[2]),
		20'(CLK_HZ / BAUD_BPS[3]), 20'(CLK_HZ / BAUD_BPS[4]), 20'(CLK_HZ / BAUD_BPS[5]),
		20'(CLK_HZ / BAUD_BPS[6]), 20'(CLK_HZ / BAUD_BPS[7])};
	localparam logic [6:0] IB_FULL = 7'(IBUF_LEN);
	localparam logic [6:0] IB_CTS  = 7'(IBUF_LEN - CTS_MARGIN);
	localparam logic [4:0] OB_FULL = 5'(OBUF_LEN);
	localparam logic [4:0] OB_HIGH = 5'(OBUF_LEN - 1);
	localparam logic [3:0] RETRIES = 4'(MAX_RETRY);

	typedef struct packed {
		smcc_mode_e                 mode;
		logic                       loaded;
		logic                       rx1, rx2, sl1, sl2;
		logic                       urx_busy;
		logic [19:0]                urx_cnt;
		logic [3:0]                 urx_bit;
		logic [7:0]                 urx_sh;
		logic                       utx_busy;
		logic [19:0]                utx_cnt;
		logic [3:0]                 utx_bit;
		logic [9:0]                 utx_sh;
		logic                       txd;
		logic [19:0]                ms_cnt;
		logic [15:0]                quiet, win;
		logic [1:0]                 esc_n, flush_n;
		logic                       hold_v;
		logic [7:0]                 hold;
		logic                       cmd_pend;
		logic [IBUF_LEN-1:0][7:0]   ibuf;
		logic [6:0]                 icnt, idx;
		smcc_byte_s                 txo;
		logic                       disc_busy, disc_req, disc_route;
		logic [3:0]                 retry;
		logic [15:0]                ackt;
		logic [OBUF_LEN-1:0][7:0]   obuf;
		logic [3:0]                 owr, ord;
		logic [4:0]                 ocnt;
		logic                       rxr;
		smcc_cfg_s                  act, stg;
		logic [7:0]                 cmd0, cmd1;
		logic [2:0]                 lpos, pdig;
		logic [15:0]                pval;
		logic                       lerr;
		logic [15:0]                ctt;
		smcc_rep_e                  rk;
		logic [2:0]                 ridx;
		logic [15:0]                rval;
		logic                       nvw;
		logic [15:0]                slpt;
		logic [31:0]                rdata;
		logic                       cts_n;
		logic                       asleep;
	} smcc_state_s;

	smcc_state_s s, next_s;

	function automatic logic [7:0] hexch(input logic [3:0] v);
		hexch = (v < 4'hA) ? 8'(8'h30 + v) : 8'(8'h37 + v);
	endfunction : hexch

	// returns {ok, nibble}
	function automatic logic [4:0] hexval(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) hexval = {1'b1, 4'(c - 8'h30)};
		else if (c >= 8'h41 && c <= 8'h46) hexval = {1'b1, 4'(c - 8'h37)};
		else hexval = 5'h00;
	endfunction : hexval

	// returns {last, byte}
	function automatic logic [8:0] rbyte(input smcc_rep_e k, input logic [2:0] i,
			input logic [15:0] v);
		logic [3:0] nib;
		nib = v[4'(15 - 4 * i) -: 4];
		unique case (k)
			R_OK:    rbyte = {i == 3'h2, OK_STR[5'(23 - 8 * i) -: 8]};
			R_ERR:   rbyte = {i == 3'h5, ERR_STR[6'(47 - 8 * i) -: 8]};
			R_VAL:   rbyte = (i == 3'h4) ? {1'b1, CH_CR} : {1'b0, hexch(nib)};
			default: rbyte = 9'h000;
		endcase
	endfunction : rbyte

	always_comb begin
		logic        mtick, rxe, rfpush, repush, pop, ibv, apply, locked;
		logic [7:0]  rxb, ibb, ob;
		logic [8:0]  rb;
		logic [19:0] div;
		logic        pkt_rdy;
		logic [4:0]  hv;
		next_s = s;
		rxe = 1'b0;
		rxb = s.urx_sh;
		ibv = 1'b0;
		ibb = 8'h00;
		apply = 1'b0;
		pop = 1'b0;
		rb = 9'h000;
		hv = 5'h00;
		mtick = 1'b0;
		rfpush = 1'b0;
		repush = 1'b0;
		pkt_rdy = 1'b0;
		ob = 8'h00;
		div = BDIV[s.act.baud];
		locked = (s.mode == M_DISC) || (s.mode == M_SEND) || (s.mode == M_ACKW);
		next_s.disc_req = 1'b0;
		next_s.nvw = 1'b0;
		next_s.rx1 = uart_rxd;
		next_s.rx2 = s.rx1;
		next_s.sl1 = sleep_rq;
		next_s.sl2 = s.sl1;

		// saved settings replace the defaults right after reset
		if (!s.loaded) begin
			next_s.loaded = 1'b1;
			if (nv_valid) begin
				next_s.act = nv_rdata;
				next_s.stg = nv_rdata;
			end
		end

		mtick = (s.ms_cnt == MS_LAST);
		next_s.ms_cnt = mtick ? 20'h00000 : 20'(s.ms_cnt + 20'h00001);

		// serial receiver: sample mid-bit, stop bit must be high
		if (!s.urx_busy) begin
			if (!s.rx2) begin
				next_s.urx_busy = 1'b1;
				next_s.urx_cnt = div >> 1;
				next_s.urx_bit = 4'h0;
			end
		end else if (s.urx_cnt != 20'h00000) begin
			next_s.urx_cnt = 20'(s.urx_cnt - 20'h00001);
		end else begin
			next_s.urx_cnt = 20'(div - 20'h00001);
			next_s.urx_bit = 4'(s.urx_bit + 4'h1);
			if (s.urx_bit == 4'h0) begin
				if (s.rx2) next_s.urx_busy = 1'b0;
			end else if (s.urx_bit == 4'h9) begin
				next_s.urx_busy = 1'b0;
				rxe = s.rx2;
			end else begin
				next_s.urx_sh = {s.rx2, s.urx_sh[7:1]};
			end
		end

		// serial transmitter
		if (!s.utx_busy) begin
			next_s.txd = 1'b1;
			if (s.ocnt != 5'h00) begin
				next_s.utx_busy = 1'b1;
				next_s.utx_sh = {1'b1, s.obuf[s.ord], 1'b0};
				next_s.utx_cnt = 20'h00000;
				next_s.utx_bit = 4'h0;
				pop = 1'b1;
			end
		end else if (s.utx_cnt != 20'h00000) begin
			next_s.utx_cnt = 20'(s.utx_cnt - 20'h00001);
		end else if (s.utx_bit == 4'hA) begin
			next_s.utx_busy = 1'b0;
		end else begin
			next_s.txd = s.utx_sh[0];
			next_s.utx_sh = {1'b1, s.utx_sh[9:1]};
			next_s.utx_cnt = 20'(div - 20'h00001);
			next_s.utx_bit = 4'(s.utx_bit + 4'h1);
		end

		// outbound byte queue: radio payload first, replies fill gaps
		rfpush = rf_rx.valid && s.rxr;
		rb = rbyte(s.rk, s.ridx, s.rval);
		repush = !rfpush && (s.rk != R_NONE) && (s.ocnt < OB_FULL);
		ob = rfpush ? rf_rx.data : rb[7:0];
		if (rfpush || repush) begin
			next_s.obuf[s.owr] = ob;
			next_s.owr = 4'(s.owr + 4'h1);
		end
		if (repush) begin
			next_s.ridx = 3'(s.ridx + 3'h1);
			if (rb[8]) next_s.rk = R_NONE;
		end
		if (pop) next_s.ord = 4'(s.ord + 4'h1);
		next_s.ocnt = 5'(s.ocnt + {4'h0, rfpush || repush} - {4'h0, pop});

		// silence and escape window timers
		if (rxe) next_s.quiet = 16'h0000;
		else if (mtick && s.quiet != 16'hFFFF) next_s.quiet = 16'(s.quiet + 16'h0001);
		if (mtick && s.esc_n != 2'h0 && s.win != 16'hFFFF) next_s.win = 16'(s.win + 16'h0001);

		// escape recognition outside command and sleep states
		if (s.mode != M_CMD && s.mode != M_SLEEP) begin
			if (rxe) begin
				if (s.esc_n == 2'h0) begin
					if (rxb == s.act.esc && s.quiet >= s.act.sw && !s.cmd_pend) begin
						next_s.esc_n = 2'h1;
						next_s.win = 16'h0000;
					end else begin
						ibv = 1'b1;
						ibb = rxb;
					end
				end else if (rxb == s.act.esc && s.esc_n != 2'h3 && s.win < s.act.sw) begin
					next_s.esc_n = 2'(s.esc_n + 2'h1);
				end else begin
					next_s.flush_n = s.esc_n;
					next_s.esc_n = 2'h0;
					next_s.hold_v = 1'b1;
					next_s.hold = rxb;
				end
			end else if (s.esc_n != 2'h0 && s.esc_n != 2'h3 && s.win >= s.act.sw) begin
				next_s.flush_n = s.esc_n;
				next_s.esc_n = 2'h0;
			end else if (s.esc_n == 2'h3 && s.quiet >= s.act.sw) begin
				next_s.esc_n = 2'h0;
				next_s.cmd_pend = 1'b1;
				next_s.rk = R_OK;
				next_s.ridx = 3'h0;
			end
		end
		// swallowed escape characters are replayed as data, then the breaking byte
		if (!ibv) begin
			if (s.flush_n != 2'h0) begin
				ibv = 1'b1;
				ibb = s.act.esc;
				next_s.flush_n = 2'(s.flush_n - 2'h1);
			end else if (s.hold_v) begin
				ibv = 1'b1;
				ibb = s.hold;
				next_s.hold_v = 1'b0;
			end
		end
		// bytes arriving while the buffer is being sent are lost; cts_n warns the host
		if (ibv && !locked && s.icnt < IB_FULL) begin
			next_s.ibuf[s.icnt] = ibb;
			next_s.icnt = 7'(s.icnt + 7'h01);
		end

		pkt_rdy = (s.icnt != 7'h00) && s.esc_n == 2'h0 && s.flush_n == 2'h0 && !s.hold_v
			&& (s.icnt == IB_FULL || s.act.gap == 16'h0000
			|| s.quiet >= s.act.gap || s.cmd_pend);

		if (mtick && s.slpt != 16'hFFFF) next_s.slpt = 16'(s.slpt + 16'h0001);

		unique case (s.mode)
			M_IDLE: begin
				if (rfpush) begin
					if (!rf_rx.last) next_s.mode = M_RX;
				end else if (pkt_rdy) begin
					next_s.mode = M_DISC;
				end else if (s.cmd_pend && s.icnt == 7'h00) begin
					next_s.mode = M_CMD;
					next_s.cmd_pend = 1'b0;
					next_s.ctt = 16'h0000;
					next_s.lpos = 3'h0;
					next_s.pdig = 3'h0;
					next_s.pval = 16'h0000;
					next_s.lerr = 1'b0;
				end else if (s.act.end_dev && ((s.act.pin_en && s.sl2)
						|| (s.act.cyc_en && s.slpt >= s.act.slper))) begin
					next_s.mode = M_SLEEP;
				end
			end
			M_DISC: begin
				if (!s.disc_busy) begin
					if (addr_ok && route_ok) begin
						next_s.mode = M_SEND;
						next_s.idx = 7'h00;
						next_s.retry = 4'h0;
					end else begin
						next_s.disc_req = 1'b1;
						next_s.disc_route = addr_ok;
						next_s.disc_busy = 1'b1;
					end
				end else if (disc_done) begin
					next_s.disc_busy = 1'b0;
					if (!disc_found) begin
						next_s.icnt = 7'h00;
						next_s.mode = M_IDLE;
					end
				end
			end
			M_SEND: begin
				if (!s.txo.valid) begin
					next_s.txo.valid = 1'b1;
					next_s.txo.data = s.ibuf[s.idx];
					next_s.txo.last = (s.idx == 7'(s.icnt - 7'h01));
				end else if (rf_tx_ready) begin
					next_s.txo.valid = 1'b0;
					next_s.idx = 7'(s.idx + 7'h01);
					if (s.txo.last) begin
						next_s.mode = M_ACKW;
						next_s.ackt = 16'h0000;
					end
				end
			end
			M_ACKW: begin
				if (mtick) next_s.ackt = 16'(s.ackt + 16'h0001);
				if (tx_ack) begin
					next_s.icnt = 7'h00;
					next_s.mode = M_IDLE;
				end else if (s.ackt >= ACK_MS) begin
					if (s.retry < RETRIES) begin
						next_s.retry = 4'(s.retry + 4'h1);
						next_s.idx = 7'h00;
						next_s.mode = M_SEND;
					end else begin
						next_s.icnt = 7'h00;
						next_s.mode = M_IDLE;
					end
				end
			end
			M_RX: begin
				if (rfpush && rf_rx.last) next_s.mode = M_IDLE;
			end
			M_CMD: begin
				if (mtick) next_s.ctt = 16'(s.ctt + 16'h0001);
				if (rxe) begin
					if (rxb == CH_CR) begin
						next_s.lpos = 3'h0;
						next_s.pdig = 3'h0;
						next_s.pval = 16'h0000;
						next_s.lerr = 1'b0;
						next_s.ridx = 3'h0;
						next_s.rk = R_OK;
						next_s.rval = 16'h0000;
						if (s.lerr || s.lpos != 3'h4) begin
							next_s.rk = R_ERR;
						end else begin
							next_s.ctt = 16'h0000;
							unique case ({s.cmd0, s.cmd1})
								CMD_SW: begin
									if (s.pdig == 3'h0) next_s.rval = s.stg.sw;
									else next_s.stg.sw = s.pval;
								end
								CMD_ESC: begin
									if (s.pdig == 3'h0) next_s.rval = {8'h00, s.stg.esc};
									else if (s.pval[15:8] != 8'h00) next_s.rk = R_ERR;
									else next_s.stg.esc = s.pval[7:0];
								end
								CMD_CMDTO: begin
									if (s.pdig == 3'h0) next_s.rval = s.stg.cmd_to;
									else next_s.stg.cmd_to = s.pval;
								end
								CMD_BAUD: begin
									if (s.pdig == 3'h0) next_s.rval = {13'h0000, s.stg.baud};
									else if (s.pval > 16'h0007) next_s.rk = R_ERR;
									else next_s.stg.baud = s.pval[2:0];
								end
								CMD_GAP: begin
									if (s.pdig == 3'h0) next_s.rval = s.stg.gap;
									else next_s.stg.gap = s.pval;
								end
								CMD_APPLY: apply = 1'b1;
								CMD_EXIT: begin
									apply = 1'b1;
									next_s.mode = M_IDLE;
								end
								CMD_SAVE: next_s.nvw = 1'b1;
								default: next_s.rk = R_ERR;
							endcase
							if (s.pdig == 3'h0 && next_s.rk == R_OK && ({s.cmd0, s.cmd1} == CMD_SW
									|| {s.cmd0, s.cmd1} == CMD_ESC
									|| {s.cmd0, s.cmd1} == CMD_CMDTO
									|| {s.cmd0, s.cmd1} == CMD_BAUD || {s.cmd0, s.cmd1} == CMD_GAP))
								next_s.rk = R_VAL;
						end
					end else if (s.lpos < 3'h4) begin
						next_s.lpos = 3'(s.lpos + 3'h1);
						if (s.lpos == 3'h0 && rxb != CH_A) next_s.lerr = 1'b1;
						if (s.lpos == 3'h1 && rxb != CH_T) next_s.lerr = 1'b1;
						if (s.lpos == 3'h2) next_s.cmd0 = rxb;
						if (s.lpos == 3'h3) next_s.cmd1 = rxb;
					end else if (rxb != CH_SP) begin
						hv = hexval(rxb);
						if (hv[4] && s.pdig < 3'h4) begin
							next_s.pval = {s.pval[11:0], hv[3:0]};
							next_s.pdig = 3'(s.pdig + 3'h1);
						end else begin
							next_s.lerr = 1'b1;
						end
					end
				end else if (s.ctt >= s.act.cmd_to) begin
					apply = 1'b1;
					next_s.mode = M_IDLE;
				end
			end
			M_SLEEP: begin
				if (s.act.pin_en ? !s.sl2 : s.slpt >= s.act.slper) next_s.mode = M_IDLE;
			end
			default: next_s.mode = M_IDLE;
		endcase
		if (apply) next_s.act = next_s.stg;
		if (next_s.mode != s.mode) next_s.slpt = 16'h0000;

		// register port: writes land in both live and staged copies
		if (wr) begin
			unique case (addr)
				A_CTRL: begin
					next_s.act.end_dev = wdata[0];
					next_s.act.pin_en = wdata[1];
					next_s.act.cyc_en = wdata[2];
					next_s.stg.end_dev = wdata[0];
					next_s.stg.pin_en = wdata[1];
					next_s.stg.cyc_en = wdata[2];
				end
				A_SW: begin next_s.act.sw = wdata[15:0]; next_s.stg.sw = wdata[15:0]; end
				A_ESC: begin next_s.act.esc = wdata[7:0]; next_s.stg.esc = wdata[7:0]; end
				A_CMDTO: begin
					next_s.act.cmd_to = wdata[15:0];
					next_s.stg.cmd_to = wdata[15:0];
				end
				A_BAUD: begin next_s.act.baud = wdata[2:0]; next_s.stg.baud = wdata[2:0]; end
				A_GAP: begin next_s.act.gap = wdata[15:0]; next_s.stg.gap = wdata[15:0]; end
				A_SLPER: begin
					next_s.act.slper = wdata[15:0];
					next_s.stg.slper = wdata[15:0];
				end
				default: ;
			endcase
		end
		next_s.rdata = 32'h00000000;
		if (rd) begin
			unique case (addr)
				A_CTRL:  next_s.rdata = {29'h00000000, s.act.cyc_en, s.act.pin_en, s.act.end_dev};
				A_SW:    next_s.rdata = {16'h0000, s.act.sw};
				A_ESC:   next_s.rdata = {24'h000000, s.act.esc};
				A_CMDTO: next_s.rdata = {16'h0000, s.act.cmd_to};
				A_BAUD:  next_s.rdata = {29'h00000000, s.act.baud};
				A_GAP:   next_s.rdata = {16'h0000, s.act.gap};
				A_SLPER: next_s.rdata = {16'h0000, s.act.slper};
				A_STAT:  next_s.rdata = {12'h000, s.ocnt, s.icnt, 1'b0, s.retry, s.mode};
				default: next_s.rdata = 32'h00000000;
			endcase
		end

		next_s.rxr = (next_s.mode == M_IDLE || next_s.mode == M_RX) && next_s.ocnt < OB_HIGH;
		next_s.cts_n = (next_s.mode == M_DISC || next_s.mode == M_SEND
			|| next_s.mode == M_ACKW || next_s.icnt >= IB_CTS);
		next_s.asleep = (next_s.mode == M_SLEEP);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.mode <= M_IDLE;
			s.rx1 <= 1'b1;
			s.rx2 <= 1'b1;
			s.txd <= 1'b1;
			s.act <= CFG_RST;
			s.stg <= CFG_RST;
		end else begin
			s <= next_s;
		end
	end

	assign rdata       = s.rdata;
	assign uart_txd    = s.txd;
	assign cts_n       = s.cts_n;
	assign asleep      = s.asleep;
	assign rf_tx       = s.txo;
	assign disc_req    = s.disc_req;
	assign disc_route  = s.disc_route;
	assign rf_rx_ready = s.rxr;
	assign nv_wdata    = s.stg;
	assign nv_wr       = s.nvw;
	assign mode        = s.mode;
endmodule : smcc_top
